// ---- logic/psbp_consts.svh ----
`ifndef PSBP_CONSTS_SVH
`define PSBP_CONSTS_SVH
// Operation
// [R1] Slave mode select turns the 8-bit data port into a host port.
// [R2] In slave mode control pins are read strobe, write strobe, select.
// [R3] One data address: writes fill outbound latch, reads give inbound.
// [R4] In slave mode the data direction register is ignored.
// [R5] Host write starts when select and write strobe are both low.
// [R6] Write end sets inbound full and done flags on phase four.
// [R7] Inbound full clears only when firmware reads the data latch; the code also clears it whenever slave mode is off.
// [R8] A host write completing while inbound full sets the overrun flag.
// [R9] Host read start clears outbound full and drives the outbound latch.
// [R10] Read end sets the done flag on phase four after phase two.
// [R11] Outbound full stays clear until firmware writes the data latch.
// [R12] Outside slave mode both full flags clear; overrun persists.
// [R13] Done flag is sticky until cleared; its enable gates the request.
// [R14] Select high means not selected; strobes are then ignored.
// [R15] Firmware write to the data latch in slave mode sets outbound full.
// [R16] Data pins are driven only while select and read strobe are low; outside slave mode the code drives them from the direction register.

// register indices; byte address is four times the index
`define PSBP_IDX_DATA 8'h08
`define PSBP_IDX_PINS 8'h09
`define PSBP_IDX_FLAG 8'h0C
`define PSBP_IDX_DDIR 8'h88
`define PSBP_IDX_STAT 8'h89
`define PSBP_IDX_MASK 8'h8C

// status, flag and mask fields
`define PSBP_STAT_INFULL 7
`define PSBP_STAT_OUTFULL 6
`define PSBP_STAT_OVRUN 5
`define PSBP_STAT_MODE 4
`define PSBP_FLAG_DONE 7
`define PSBP_MASK_DONE 7

// reset values
`define PSBP_STAT_RST 8'h07
`define PSBP_DDIR_RST 8'hFF
`define PSBP_FLAG_RST 8'h00
`define PSBP_MASK_RST 8'h00
`define PSBP_CTL_DIR_RST 3'h7

// instruction phases, one clock each
`define PSBP_PHASE_RST 2'h0
`define PSBP_PHASE_TWO 2'h1
`define PSBP_PHASE_FOUR 2'h3
`endif

// ---- logic/psbp_pkg.sv ----
package psbp_pkg;
  typedef enum logic [1:0] {
    psbp_idle,
    psbp_wait_two,
    psbp_wait_four
  } psbp_done_type;
endpackage : psbp_pkg

// ---- logic/psbp_port.sv ----
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "psbp_consts.svh"
module psbp_port #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic irq,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic [DATA_W-1:0] data_oe_n,
  input wire logic [2:0] ctl_in,
  output logic [2:0] ctl_out,
  output logic [2:0] ctl_oe_n
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  generate
    if (DATA_W != 8) begin : g_bad_width
      $error("data width must be 8");
    end
    if (ADDR_W < 10) begin : g_bad_addr
      $error("address width must be at least 10");
    end
  endgenerate

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic psbp_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [7:0] idx
  );
    logic [ADDR_W-1:0] byte_addr;
    byte_addr = ADDR_W'({idx, 2'b00});
    psbp_hit = (addr == byte_addr);
  endfunction : psbp_hit

  wire hit_data = psbp_hit(paddr, `PSBP_IDX_DATA);
  wire hit_pins = psbp_hit(paddr, `PSBP_IDX_PINS);
  wire hit_flag = psbp_hit(paddr, `PSBP_IDX_FLAG);
  wire hit_ddir = psbp_hit(paddr, `PSBP_IDX_DDIR);
  wire hit_stat = psbp_hit(paddr, `PSBP_IDX_STAT);
  wire hit_mask = psbp_hit(paddr, `PSBP_IDX_MASK);
  wire mapped = hit_data | hit_pins | hit_flag |
                hit_ddir | hit_stat | hit_mask;

  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr_en = access & pwrite & mapped;
  wire rd_setup = setup & ~pwrite;
  wire rd_access = access & ~pwrite;

  wire wr_data = wr_en & hit_data;
  wire wr_pins = wr_en & hit_pins;
  wire wr_ddir = wr_en & hit_ddir;
  wire wr_stat = wr_en & hit_stat;
  wire wr_mask = wr_en & hit_mask;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [1:0] phase;
  logic [2:0] ctl_s1;
  logic [2:0] ctl_s2;
  logic [DATA_W-1:0] din_s1;
  logic [DATA_W-1:0] din_s2;
  logic wr_prev;
  logic rd_prev;
  logic [DATA_W-1:0] in_latch;
  logic [DATA_W-1:0] out_latch;
  logic [DATA_W-1:0] data_dir;
  logic [2:0] pin_latch;
  logic [2:0] ctl_dir;
  logic slave_mode_select;
  logic inbound_full_flag;
  logic outbound_full_flag;
  logic inbound_overrun_flag;
  logic transfer_done_flag;
  logic transfer_done_enable;
  psbp_pkg::psbp_done_type done_state;
  psbp_pkg::psbp_done_type next_done_state;
  logic done_is_write;
  logic next_done_is_write;
  logic [31:0] rd_hold;
  logic cap_full_clr;
  logic cap_done_clr;

  // ---------------------------------------------------------------
  // host strobes
  // ---------------------------------------------------------------
  wire read_strobe_pin = ctl_s2[0];
  wire write_strobe_pin = ctl_s2[1];
  wire select_pin = ctl_s2[2];

  // select high masks both strobes
  wire host_sel = slave_mode_select & ~select_pin; // [R1] [R2] [R14]
  wire wr_act = host_sel & ~write_strobe_pin; // [R5]
  wire rd_act = host_sel & ~read_strobe_pin; // [R9]
  wire wr_end = wr_prev & ~wr_act; // [R6]
  wire rd_end = rd_prev & ~rd_act; // [R10]
  wire rd_start = rd_act & ~rd_prev; // [R9]
  wire any_end = wr_end | rd_end;

  wire is_phase_two = (phase == `PSBP_PHASE_TWO);
  wire is_phase_four = (phase == `PSBP_PHASE_FOUR);
  wire done_set = (done_state == psbp_pkg::psbp_wait_four) & is_phase_four;
  wire wr_done = done_set & done_is_write;

  // ---------------------------------------------------------------
  // completion timing
  // ---------------------------------------------------------------
  // a new end while pending restarts the wait and keeps a write kind
  always_comb begin
    next_done_state = done_state;
    next_done_is_write = done_is_write;
    case (done_state)
      psbp_pkg::psbp_idle: begin
        next_done_is_write = 1'b0;
      end
      psbp_pkg::psbp_wait_two: begin
        if (is_phase_two) begin
          next_done_state = psbp_pkg::psbp_wait_four;
        end
      end
      psbp_pkg::psbp_wait_four: begin
        if (is_phase_four) begin
          next_done_state = psbp_pkg::psbp_idle;
          next_done_is_write = 1'b0;
        end
      end
      default: begin
        next_done_state = psbp_pkg::psbp_idle;
        next_done_is_write = 1'b0;
      end
    endcase
    if (any_end) begin
      next_done_state = psbp_pkg::psbp_wait_two; // [R6] [R10]
      if (done_state == psbp_pkg::psbp_idle || done_set) begin
        next_done_is_write = wr_end;
      end else begin
        next_done_is_write = done_is_write | wr_end;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_state <= psbp_pkg::psbp_idle;
      done_is_write <= 1'b0;
    end else begin
      done_state <= next_done_state;
      done_is_write <= next_done_is_write;
    end
  end

  // ---------------------------------------------------------------
  // phase counter and synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= `PSBP_PHASE_RST;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_s1 <= 3'h7;
      ctl_s2 <= 3'h7;
      din_s1 <= '0;
      din_s2 <= '0;
    end else begin
      ctl_s1 <= ctl_in;
      ctl_s2 <= ctl_s1;
      din_s1 <= data_in;
      din_s2 <= din_s1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_prev <= 1'b0;
      rd_prev <= 1'b0;
    end else begin
      wr_prev <= wr_act;
      rd_prev <= rd_act;
    end
  end

  // ---------------------------------------------------------------
  // data latches
  // ---------------------------------------------------------------
  // inbound latch keeps the last byte seen while the write is active
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_latch <= '0;
    end else if (wr_act) begin
      in_latch <= din_s2; // [R3]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_latch <= '0;
    end else if (wr_data) begin
      out_latch <= pwdata[DATA_W-1:0]; // [R3]
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_dir <= `PSBP_DDIR_RST;
      pin_latch <= 3'h0;
      ctl_dir <= `PSBP_CTL_DIR_RST;
      slave_mode_select <= 1'b0;
      transfer_done_enable <= 1'b0;
    end else begin
      if (wr_ddir) begin
        data_dir <= pwdata[DATA_W-1:0];
      end
      if (wr_pins) begin
        pin_latch <= pwdata[2:0];
      end
      if (wr_stat) begin
        ctl_dir <= pwdata[2:0];
        slave_mode_select <= pwdata[`PSBP_STAT_MODE];
      end
      if (wr_mask) begin
        transfer_done_enable <= pwdata[`PSBP_MASK_DONE];
      end
    end
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  // read clears take effect at the access edge, only for what was shown
  wire full_clr = rd_access & hit_data & cap_full_clr; // [R7]
  wire done_clr = rd_access & hit_flag & cap_done_clr; // [R13]
  wire ovrun_clr = wr_stat & ~pwdata[`PSBP_STAT_OVRUN];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inbound_full_flag <= 1'b0;
    end else if (!slave_mode_select) begin
      inbound_full_flag <= 1'b0; // [R12]
    end else if (wr_done) begin
      inbound_full_flag <= 1'b1; // [R6]
    end else if (full_clr) begin
      inbound_full_flag <= 1'b0; // [R7]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inbound_overrun_flag <= 1'b0;
    end else if (wr_done & inbound_full_flag) begin
      inbound_overrun_flag <= 1'b1; // [R8]
    end else if (ovrun_clr) begin
      inbound_overrun_flag <= 1'b0; // [R12]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outbound_full_flag <= 1'b0;
    end else if (!slave_mode_select) begin
      outbound_full_flag <= 1'b0; // [R12]
    end else if (wr_data) begin
      outbound_full_flag <= 1'b1; // [R15] [R11]
    end else if (rd_start) begin
      outbound_full_flag <= 1'b0; // [R9]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      transfer_done_flag <= 1'b0;
    end else if (done_set) begin
      transfer_done_flag <= 1'b1; // [R6] [R10] [R13]
    end else if (done_clr) begin
      transfer_done_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  wire [7:0] stat_val = {inbound_full_flag, outbound_full_flag,
                         inbound_overrun_flag, slave_mode_select,
                         1'b0, ctl_dir};
  wire [7:0] flag_val = {transfer_done_flag, 7'h00};
  wire [7:0] mask_val = {transfer_done_enable, 7'h00};
  wire [7:0] data_val = slave_mode_select ? in_latch : din_s2; // [R3]

  wire [7:0] rd_sel =
    hit_data ? data_val :
    hit_pins ? {5'h00, ctl_s2} :
    hit_flag ? flag_val :
    hit_ddir ? data_dir :
    hit_stat ? stat_val :
    hit_mask ? mask_val : 8'h00;

  // read data is sampled in the setup cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_hold <= 32'h0000_0000;
      cap_full_clr <= 1'b0;
      cap_done_clr <= 1'b0;
    end else if (rd_setup) begin
      rd_hold <= {24'h00_0000, rd_sel};
      cap_full_clr <= hit_data;
      cap_done_clr <= transfer_done_flag;
    end
  end

  assign pready = 1'b1;
  assign prdata = rd_hold;
  assign pslverr = access & ~mapped;

  // ---------------------------------------------------------------
  // interrupt and pins
  // ---------------------------------------------------------------
  assign irq = transfer_done_flag & transfer_done_enable; // [R13]

  assign data_out = out_latch;
  // direction register only counts outside slave mode
  assign data_oe_n = slave_mode_select ? ~{DATA_W{rd_act}} :
                     data_dir; // [R4] [R16] [R9]
  assign ctl_out = pin_latch;
  assign ctl_oe_n = slave_mode_select ? 3'h7 : ctl_dir; // [R2]

endmodule : psbp_port

// ---- verif/psbp_port_chk.sv ----
`timescale 1ns/1ps
`include "psbp_consts.svh"
// ----------------------------------------
// port checker
// ----------------------------------------
module psbp_port_chk #(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic [7:0] data_oe_n,
  input wire logic [2:0] ctl_in,
  input wire logic [2:0] ctl_oe_n
);
  localparam logic [11:0] A_ST = {2'h0, `PSBP_IDX_STAT, 2'h0};
  localparam logic [11:0] A_MK = {2'h0, `PSBP_IDX_MASK, 2'h0};
  localparam logic [11:0] A_FL = {2'h0, `PSBP_IDX_FLAG, 2'h0};
  logic mode;
  logic en;
  wire acc = psel && penable;
  wire st_wr = acc && pwrite && paddr == A_ST;
  wire mk_wr = acc && pwrite && paddr == A_MK;
  wire fl_rd = acc && !pwrite && paddr == A_FL;
  wire mapped = paddr inside {12'h020, 12'h024, 12'h030, 12'h220, 12'h224,
    12'h230};
  wire rd_on = mode && !ctl_in[2] && !ctl_in[0];
  wire wr_on = mode && !ctl_in[2] && !ctl_in[1];
  // shadow of mode and done enable, taken from bus writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= 1'b0;
      en <= 1'b0;
    end else begin
      if (st_wr) mode <= pwdata[4];
      if (mk_wr) en <= pwdata[7];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_addr_err: assert property (acc |-> pslverr == !mapped)
    else $error("pslverr does not match decode");
  a_oe_idle: assert property (
    (mode && !rd_on)[*5] |-> data_oe_n == 8'hFF)
    else $error("data pins driven without host read");
  a_oe_read: assert property (
    rd_on[*5] |-> data_oe_n == 8'h00)
    else $error("data pins not driven in host read");
  a_ctl_pins_in: assert property (
    mode && $past(mode) |-> ctl_oe_n == 3'h7)
    else $error("control pins driven in slave mode");
  a_irq_masked: assert property (!en && !$past(en) |-> !irq)
    else $error("irq while done enable clear");
  a_irq_sticky: assert property (
    irq && !fl_rd && !mk_wr && !$past(fl_rd) && !$past(mk_wr) |=> irq)
    else $error("irq dropped without clear");
  a_read_done: assert property (
    (en && rd_on)[*3] ##1 (!rd_on && !irq) |-> !irq[*4] ##[1:8] irq)
    else $error("read completion timing wrong");
  a_write_done: assert property (
    (en && wr_on)[*3] ##1 (!wr_on && !irq) |-> !irq[*4] ##[1:8] irq)
    else $error("write completion timing wrong");
endmodule : psbp_port_chk

bind psbp_port psbp_port_chk #(.ADDR_W(ADDR_W)) i_chk (.clk(clk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .irq(irq),
  .data_oe_n(data_oe_n), .ctl_in(ctl_in), .ctl_oe_n(ctl_oe_n));

// ---- verif/psbp_host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// host bus master model
// ----------------------------------------
module psbp_host_model (
  input wire logic clk,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe_n,
  output logic [7:0] data_in,
  output logic [2:0] ctl_in
);
  initial begin
    ctl_in = 3'h7;
    data_in = 8'h00;
  end
  // strobes low five cycles, then high five; released bus shows inverse
  task automatic xfer(input logic r, input logic [7:0] wd,
    output logic [7:0] q);
    @(posedge clk);
    if (!r) data_in <= wd;
    ctl_in <= r ? 3'h2 : 3'h1;
    repeat (5) @(posedge clk);
    q = (data_oe_n === 8'h00) ? data_out : 8'hXX;
    ctl_in <= 3'h7;
    data_in <= ~wd;
    repeat (5) @(posedge clk);
  endtask : xfer
endmodule : psbp_host_model

// ---- verif/psbp_port_tb_top.sv ----
`timescale 1ns/1ps
`include "psbp_consts.svh"
module psbp_port_tb_top;
  logic clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic pready;
  logic pslverr;
  logic irq;
  logic err;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [7:0] d_in;
  logic [7:0] d_out;
  logic [7:0] oe_n;
  logic [7:0] q;
  logic [2:0] c_in;
  logic [2:0] c_oe_n;
  logic [2:0] c_out;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  psbp_port i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .irq(irq), .data_in(d_in),
    .data_out(d_out), .data_oe_n(oe_n), .ctl_in(c_in), .ctl_out(c_out),
    .ctl_oe_n(c_oe_n));
  psbp_host_model i_host (.clk(clk), .data_out(d_out), .data_oe_n(oe_n),
    .data_in(d_in), .ctl_in(c_in));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] ix,
    input logic [7:0] v);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, ix, 2'h0};
    pwdata <= {24'h0, v};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rr(input logic [7:0] ix, input logic [7:0] e,
    input string nm);
    apb(1'b0, ix, 8'h00);
    chk(nm, rd, {24'h0, e});
  endtask : rr
  task automatic tend(input int n);
    $display("test %0d done", n);
  endtask : tend
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rr(`PSBP_IDX_STAT, 8'h07, "status reset");
    rr(`PSBP_IDX_FLAG, 8'h00, "flag reset");
    rr(`PSBP_IDX_MASK, 8'h00, "mask reset");
    apb(1'b0, 8'h40, 8'h00);
    chk("unmapped err", {31'h0, err}, 32'h1);
    tend(1);
    apb(1'b1, `PSBP_IDX_STAT, 8'h17);
    apb(1'b1, `PSBP_IDX_MASK, 8'h80);
    apb(1'b1, `PSBP_IDX_DDIR, 8'h00);
    apb(1'b1, `PSBP_IDX_DATA, 8'hA5);
    rr(`PSBP_IDX_STAT, 8'h57, "out full set");
    chk("oe idle", {24'h0, oe_n}, 32'hFF);
    chk("ctl oe slave", {29'h0, c_oe_n}, 32'h7);
    tend(2);
    i_host.xfer(1'b1, 8'h00, q);
    chk("host read", {24'h0, q}, 32'hA5);
    repeat (8) @(posedge clk);
    chk("irq read", {31'h0, irq}, 32'h1);
    rr(`PSBP_IDX_STAT, 8'h17, "out full clear");
    rr(`PSBP_IDX_FLAG, 8'h80, "done read");
    rr(`PSBP_IDX_FLAG, 8'h00, "done cleared");
    chk("irq cleared", {31'h0, irq}, 32'h0);
    tend(3);
    i_host.xfer(1'b0, 8'h3C, q);
    repeat (8) @(posedge clk);
    rr(`PSBP_IDX_STAT, 8'h97, "in full set");
    rr(`PSBP_IDX_FLAG, 8'h80, "done write");
    rr(`PSBP_IDX_DATA, 8'h3C, "in latch");
    rr(`PSBP_IDX_STAT, 8'h17, "in full clear");
    tend(4);
    i_host.xfer(1'b0, 8'h11, q);
    i_host.xfer(1'b0, 8'h22, q);
    repeat (8) @(posedge clk);
    rr(`PSBP_IDX_STAT, 8'hB7, "overrun set");
    rr(`PSBP_IDX_DATA, 8'h22, "newest byte");
    apb(1'b1, `PSBP_IDX_STAT, 8'h17);
    rr(`PSBP_IDX_STAT, 8'h17, "overrun clear");
    tend(5);
    apb(1'b1, `PSBP_IDX_MASK, 8'h00);
    rr(`PSBP_IDX_FLAG, 8'h80, "done sticky");
    i_host.xfer(1'b0, 8'h33, q);
    repeat (8) @(posedge clk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rr(`PSBP_IDX_FLAG, 8'h80, "done masked");
    tend(6);
    i_host.xfer(1'b0, 8'h44, q);
    repeat (8) @(posedge clk);
    apb(1'b1, `PSBP_IDX_DATA, 8'h5A);
    apb(1'b1, `PSBP_IDX_PINS, 8'h05);
    apb(1'b1, `PSBP_IDX_STAT, 8'h20);
    rr(`PSBP_IDX_STAT, 8'h20, "mode off");
    chk("oe direction", {24'h0, oe_n}, 32'h00);
    chk("ctl oe", {29'h0, c_oe_n}, 32'h0);
    chk("ctl out", {29'h0, c_out}, 32'h5);
    rr(`PSBP_IDX_PINS, 8'h07, "pins read");
    rr(`PSBP_IDX_DATA, 8'hBB, "data pins read");
    tend(7);
    give_verdict();
  end
endmodule : psbp_port_tb_top
